/* rrs_pkg.sv */
// package for the rail b sequencing control block
// assumes a 40 MHz mclk and a simple byte-wide register port from the serial host logic
// Behaviour
// RULE1: the rail is on while its enable bit is 1 (reset value) and off while it is 0.
// RULE2: the rail stays on in light and deep sleep unless the matching sleep-off bit 6 or 5 is 1.
// RULE3: the two-bit limit select picks 0.155A, 0.245A, 0.365A (default) or 0.46A.
// RULE4: with the reset-influence bit set, the rail turning off drives the system reset output.
// RULE5: with limit shutdown set, hitting the limit shuts the rail off and restarts it after 10ms; the code ignores the limit during the turn-off delay.
// RULE6: when the upstream rail drops, this rail drops too unless its hold bit is 1 (default).
// RULE7: the turn-on delay code gives none, 0.25ms (default), 0.5ms or 1.0ms.
// RULE8: the turn-on delay is counted from the sequencing trigger before the rail may turn on.
// RULE9: the turn-off delay is the five-bit field times 0.25ms, default 2.
// RULE10: the turn-off delay is counted from the sleep trigger before the rail may turn off.
// RULE11: the voltage code maps to 0.8V + code*12.5mV or 0.6V + code*9.375mV by reference.
// RULE12: all delays count ticks of one 0.25ms time base.
package rrs_pkg;
   // ----------------------------------------------------------------
   // register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RRS_ADDR_CTRL = 8'h67;
   localparam logic [7:0] RRS_ADDR_DLY = 8'h68;
   localparam logic [7:0] RRS_ADDR_RSVD = 8'h69;
   localparam logic [7:0] RRS_RST_CTRL = 8'h90;
   localparam logic [7:0] RRS_RST_DLY = 8'hA2;
   localparam logic [7:0] RRS_RST_RSVD = 8'h40;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RRS_B_EN = 7;
   localparam int RRS_B_LSLP = 6;
   localparam int RRS_B_DSLP = 5;
   localparam int RRS_B_ILIM = 3;
   localparam int RRS_B_RSTI = 2;
   localparam int RRS_B_LSHDN = 1;
   localparam int RRS_B_HOLD = 7;
   localparam int RRS_B_ONDLY = 5;
   localparam int RRS_B_OFFDLY = 0;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int RRS_CLK_KHZ = 40000;
   localparam int RRS_TICK_US = 250;
   localparam int RRS_TICK_CYC = RRS_CLK_KHZ * RRS_TICK_US / 1000;
   localparam int RRS_RESTART_MS = 10;
   localparam int RRS_RESTART_TICKS = RRS_RESTART_MS * 1000 / RRS_TICK_US;
   // limit thresholds in mA, index by select code
   localparam logic [9:0] RRS_ILIM_MA0 = 10'd155;
   localparam logic [9:0] RRS_ILIM_MA1 = 10'd245;
   localparam logic [9:0] RRS_ILIM_MA2 = 10'd365;
   localparam logic [9:0] RRS_ILIM_MA3 = 10'd460;
   // voltage bases and 0.8V step in microvolts, 0.6V step in nanovolts
   localparam int RRS_V800_BASE_UV = 800000;
   localparam int RRS_V800_STEP_UV = 12500;
   localparam int RRS_V600_BASE_UV = 600000;
   localparam int RRS_V600_STEP_NV = 9375000;
   typedef enum logic [2:0] {RRS_OFF, RRS_ON_WAIT, RRS_ON, RRS_OFF_WAIT, RRS_LIM_REST}
      rrs_state_t;
endpackage

/* rrs_tick.sv */
// time base divider giving one enable pulse per 0.25ms step
// assumes one mclk domain; tick is a single-cycle pulse, clr restarts the phase
`timescale 1ns/1ps
module rrs_tick #(
   parameter int CYC = rrs_pkg::RRS_TICK_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // phase restart from the sequencer
   input wire logic clr,
   // tick out
   output logic tick
);
   import rrs_pkg::*;
   logic [15:0] cnt_q, cnt_d;
   logic tick_d;
   // wrap counter, tick registered so it is glitch free
   // clr starts a fresh full period, so a delay never comes up short
   always_comb begin
      tick_d = (cnt_q == 16'(CYC - 1)) && !clr;
      cnt_d = (tick_d || clr) ? 16'h0000 : cnt_q + 16'h0001;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d; // RULE12
         tick <= tick_d;
      end
   end
endmodule

/* rrs_rail_ctrl.sv */
// sequencing control for regulator rail b
// assumes byte register port from serial host logic, pin inputs asynchronous to mclk
`timescale 1ns/1ps
module rrs_rail_ctrl #(
   parameter int TICK_CYC = rrs_pkg::RRS_TICK_CYC,
   parameter int RESTART_TICKS = rrs_pkg::RRS_RESTART_TICKS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // sequencing and mode pins
   input wire logic seq_on_trig,
   input wire logic light_sleep_mode,
   input wire logic deep_sleep_mode,
   input wire logic upstream_off,
   input wire logic current_limit_hit,
   // analog side
   input wire logic [7:0] rail_b_voltage_code,
   input wire logic ref_is_600mv,
   output logic rail_b_on,
   output logic [9:0] rail_b_limit_ma,
   output logic [21:0] rail_b_target_uv,
   output logic system_reset_out
);
   import rrs_pkg::*;

   // ----------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------
   logic tick;
   logic tick_clr;
   rrs_tick #(.CYC(TICK_CYC)) u_tick (.mclk(mclk), .rst(rst), .clr(tick_clr), .tick(tick));

   // ----------------------------------------------------------------
   // pin synchronisers, three stages, change taken when 2 and 3 agree
   // ----------------------------------------------------------------
   localparam int NP = 5;
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
   assign pin_raw = {current_limit_hit, upstream_off, deep_sleep_mode, light_sleep_mode,
                     seq_on_trig};
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_pin
         assign pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
      end
   endgenerate
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end
   logic trig_on, lsl, dsl, up_off, ilim;
   assign {ilim, up_off, dsl, lsl, trig_on} = pin_q;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d, dly_q, dly_d, rsvd_q, rsvd_d, rdata_d;
   always_comb begin
      ctrl_d = ctrl_q;
      dly_d = dly_q;
      rsvd_d = rsvd_q;
      if (reg_wr) begin
         case (reg_addr)
            RRS_ADDR_CTRL: ctrl_d = reg_wdata;
            RRS_ADDR_DLY: dly_d = reg_wdata;
            RRS_ADDR_RSVD: rsvd_d = reg_wdata;
            default: ;
         endcase
      end
      // unmapped reads return zero
      case (reg_addr)
         RRS_ADDR_CTRL: rdata_d = ctrl_q;
         RRS_ADDR_DLY: rdata_d = dly_q;
         RRS_ADDR_RSVD: rdata_d = rsvd_q;
         default: rdata_d = 8'h00;
      endcase
      if (!reg_rd) rdata_d = reg_rdata;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= RRS_RST_CTRL;
         dly_q <= RRS_RST_DLY;
         rsvd_q <= RRS_RST_RSVD;
         reg_rdata <= 8'h00;
      end else begin
         ctrl_q <= ctrl_d;
         dly_q <= dly_d;
         rsvd_q <= rsvd_d;
         reg_rdata <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // derived controls
   // ----------------------------------------------------------------
   logic en, off_lsl, off_dsl, rst_inf, lim_shdn, hold;
   logic [1:0] ilim_sel, on_code;
   logic [4:0] off_code;
   logic [5:0] on_ticks;
   logic want_on, sleep_off;
   assign en = ctrl_q[RRS_B_EN];
   assign off_lsl = ctrl_q[RRS_B_LSLP];
   assign off_dsl = ctrl_q[RRS_B_DSLP];
   assign ilim_sel = ctrl_q[RRS_B_ILIM +: 2];
   assign rst_inf = ctrl_q[RRS_B_RSTI];
   assign lim_shdn = ctrl_q[RRS_B_LSHDN];
   assign hold = dly_q[RRS_B_HOLD];
   assign on_code = dly_q[RRS_B_ONDLY +: 2];
   assign off_code = dly_q[RRS_B_OFFDLY +: 5];
   // 00 none, 01 one tick, 10 two, 11 four ticks
   assign on_ticks = (on_code == 2'b11) ? 6'd4 : {4'b0000, on_code}; // RULE7
   assign sleep_off = (lsl && off_lsl) || (dsl && off_dsl); // RULE2
   // upstream drop keeps this rail off while it lasts unless hold is set
   logic up_latch_q, up_latch_d;
   assign up_latch_d = up_off ? !hold : 1'b0; // RULE6
   assign want_on = en && trig_on && !up_latch_q; // RULE1

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   rrs_state_t st_q, st_d;
   logic [8:0] cnt_q, cnt_d;
   logic on_d, rstout_d;
   logic [9:0] lim_d;
   logic [21:0] uv_d;
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         RRS_OFF: begin
            if (want_on && !sleep_off) begin
               st_d = (on_ticks == 6'd0) ? RRS_ON : RRS_ON_WAIT;
               cnt_d = {3'b000, on_ticks};
            end
         end
         RRS_ON_WAIT: begin
            if (!want_on || sleep_off) st_d = RRS_OFF;
            else if (tick) begin
               cnt_d = cnt_q - 9'd1;
               if (cnt_q == 9'd1) st_d = RRS_ON; // RULE8
            end
         end
         RRS_ON: begin
            if (!want_on) st_d = RRS_OFF; // RULE1
            else if (ilim && lim_shdn) begin
               st_d = RRS_LIM_REST; // RULE5
               cnt_d = 9'(RESTART_TICKS);
            end else if (sleep_off) begin
               st_d = (off_code == 5'd0) ? RRS_OFF : RRS_OFF_WAIT;
               cnt_d = {4'b0000, off_code}; // RULE9
            end
         end
         RRS_OFF_WAIT: begin
            if (!want_on) st_d = RRS_OFF;
            else if (!sleep_off) st_d = RRS_ON;
            else if (tick) begin
               cnt_d = cnt_q - 9'd1;
               if (cnt_q == 9'd1) st_d = RRS_OFF; // RULE10
            end
         end
         RRS_LIM_REST: begin
            if (!want_on) st_d = RRS_OFF;
            else if (tick) begin
               cnt_d = cnt_q - 9'd1;
               if (cnt_q == 9'd1) st_d = RRS_ON; // RULE5
            end
         end
         default: st_d = RRS_OFF;
      endcase
      // restart the time base on entry to any wait, so each delay is a full count
      tick_clr = (st_d != st_q) && (st_d != RRS_ON) && (st_d != RRS_OFF); // RULE12
      on_d = (st_d == RRS_ON) || (st_d == RRS_OFF_WAIT);
      // reset held low while rail is off only when influence is set
      rstout_d = !(rst_inf && !on_d); // RULE4
      case (ilim_sel)
         2'b00: lim_d = RRS_ILIM_MA0; // RULE3
         2'b01: lim_d = RRS_ILIM_MA1;
         2'b10: lim_d = RRS_ILIM_MA2;
         default: lim_d = RRS_ILIM_MA3;
      endcase
      if (ref_is_600mv)
         // step scaled to microvolts first; the nanovolt product overflows an int
         uv_d = 22'(RRS_V600_BASE_UV + int'(rail_b_voltage_code) * (RRS_V600_STEP_NV / 1000));
      else
         uv_d = 22'(RRS_V800_BASE_UV + int'(rail_b_voltage_code) * RRS_V800_STEP_UV); // RULE11
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= RRS_OFF;
         cnt_q <= 9'd0;
         up_latch_q <= 1'b0;
         rail_b_on <= 1'b0;
         system_reset_out <= 1'b1;
         rail_b_limit_ma <= RRS_ILIM_MA2;
         rail_b_target_uv <= 22'd0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         up_latch_q <= up_latch_d;
         rail_b_on <= on_d;
         system_reset_out <= rstout_d;
         rail_b_limit_ma <= lim_d;
         rail_b_target_uv <= uv_d;
      end
   end
endmodule

/* rrs_rail_ctrl_asserts.sv */
// port checker for the rail b sequencing block
// assumes the bench keeps seq_on_trig high whenever the rail should be up
`timescale 1ns/1ps
module rrs_chk
   import rrs_pkg::*;
#(
   parameter int TICK_CYC = RRS_TICK_CYC,
   parameter int RESTART_TICKS = RRS_RESTART_TICKS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // pins
   input wire logic seq_on_trig,
   input wire logic light_sleep_mode,
   input wire logic deep_sleep_mode,
   input wire logic upstream_off,
   input wire logic current_limit_hit,
   // analog side
   input wire logic [7:0] rail_b_voltage_code,
   input wire logic ref_is_600mv,
   input wire logic rail_b_on,
   input wire logic [9:0] rail_b_limit_ma,
   input wire logic [21:0] rail_b_target_uv,
   input wire logic system_reset_out
);
   // ----------------------------------------------------------------
   // shadow of the host registers
   // ----------------------------------------------------------------
   logic [7:0] c_q, d_q, r_q, sh;
   // shadow follows writes so reads and outputs can be judged
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         c_q <= RRS_RST_CTRL;
         d_q <= RRS_RST_DLY;
         r_q <= RRS_RST_RSVD;
      end else if (reg_wr) begin
         if (reg_addr == RRS_ADDR_CTRL) c_q <= reg_wdata;
         if (reg_addr == RRS_ADDR_DLY) d_q <= reg_wdata;
         if (reg_addr == RRS_ADDR_RSVD) r_q <= reg_wdata;
      end
   end
   // unmapped places read back as zero
   always_comb begin
      sh = 8'h00;
      if (reg_addr == RRS_ADDR_CTRL) sh = c_q;
      if (reg_addr == RRS_ADDR_DLY) sh = d_q;
      if (reg_addr == RRS_ADDR_RSVD) sh = r_q;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_up_drop;
      $rose(upstream_off) && !d_q[RRS_B_HOLD];
   endsequence
   sequence s_steady_on;
      (rail_b_on && seq_on_trig && c_q[7:5] == 3'b100 && !c_q[1] && d_q[7])[*8];
   endsequence
   property p_rd;
      reg_rd |=> reg_rdata == $past(sh);
   endproperty
   property p_lim;
      (!reg_wr)[*3] |-> rail_b_limit_ma == (c_q[4:3] == 2'b00 ? RRS_ILIM_MA0 :
         c_q[4:3] == 2'b01 ? RRS_ILIM_MA1 : c_q[4:3] == 2'b10 ? RRS_ILIM_MA2 : RRS_ILIM_MA3);
   endproperty
   property p_tgt;
      ($stable(rail_b_voltage_code) && $stable(ref_is_600mv))[*3] |-> rail_b_target_uv ==
         (ref_is_600mv ? 22'(RRS_V600_BASE_UV + rail_b_voltage_code * 9375) :
         22'(RRS_V800_BASE_UV + rail_b_voltage_code * RRS_V800_STEP_UV));
   endproperty
   property p_en;
      (!c_q[RRS_B_EN])[*4] |-> !rail_b_on;
   endproperty
   property p_hold;
      s_up_drop ##1 (upstream_off && !d_q[RRS_B_HOLD])[*8] |-> !rail_b_on;
   endproperty
   property p_stay;
      s_steady_on |=> rail_b_on;
   endproperty
   property p_on;
      $rose(rail_b_on) |-> $past(seq_on_trig, 3);
   endproperty
   property p_rst_fall;
      $fell(system_reset_out) |-> ##[0:2] !rail_b_on;
   endproperty
   property p_rst_hi;
      rail_b_on[*3] |-> system_reset_out;
   endproperty
   a_rd: assert property (p_rd) else $error("read data differs from shadow");
   a_lim: assert property (p_lim) else $error("limit threshold wrong");
   a_tgt: assert property (p_tgt) else $error("target voltage wrong");
   a_en: assert property (p_en) else $error("rail on while disabled");
   a_hold: assert property (p_hold) else $error("rail kept on after upstream drop");
   a_stay: assert property (p_stay) else $error("rail dropped without cause");
   a_on: assert property (p_on) else $error("rail rose without trigger");
   a_rst_fall: assert property (p_rst_fall) else $error("reset out low, rail on");
   a_rst_hi: assert property (p_rst_hi) else $error("reset out low while rail on");
endmodule
bind rrs_rail_ctrl rrs_chk #(
   .TICK_CYC(TICK_CYC),
   .RESTART_TICKS(RESTART_TICKS)
) i_rrs_chk (
   .mclk(mclk),
   .rst(rst),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata),
   .seq_on_trig(seq_on_trig),
   .light_sleep_mode(light_sleep_mode),
   .deep_sleep_mode(deep_sleep_mode),
   .upstream_off(upstream_off),
   .current_limit_hit(current_limit_hit),
   .rail_b_voltage_code(rail_b_voltage_code),
   .ref_is_600mv(ref_is_600mv),
   .rail_b_on(rail_b_on),
   .rail_b_limit_ma(rail_b_limit_ma),
   .rail_b_target_uv(rail_b_target_uv),
   .system_reset_out(system_reset_out)
);

/* tb.sv */
// self-checking bench for rrs_rail_ctrl, random and corner stimulus
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module tb;
   import rrs_pkg::*;
   logic mclk, rst, reg_wr, reg_rd, seq_on_trig, light_sleep_mode, deep_sleep_mode;
   logic upstream_off, current_limit_hit, ref_is_600mv, rail_b_on, system_reset_out;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rail_b_voltage_code;
   logic [9:0] rail_b_limit_ma;
   logic [21:0] rail_b_target_uv;
   int failures, total_checks, n;
   // short tick and restart counts keep the run brief
   rrs_rail_ctrl #(.TICK_CYC(10), .RESTART_TICKS(3)) i_rrs_rail_ctrl (
      .mclk(mclk),
      .rst(rst),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .seq_on_trig(seq_on_trig),
      .light_sleep_mode(light_sleep_mode),
      .deep_sleep_mode(deep_sleep_mode),
      .upstream_off(upstream_off),
      .current_limit_hit(current_limit_hit),
      .rail_b_voltage_code(rail_b_voltage_code),
      .ref_is_600mv(ref_is_600mv),
      .rail_b_on(rail_b_on),
      .rail_b_limit_ma(rail_b_limit_ma),
      .rail_b_target_uv(rail_b_target_uv),
      .system_reset_out(system_reset_out)
   );
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic int exp_uv(input logic [7:0] c, input logic r);
      return r ? 600000 + c * 9375 : 800000 + c * 12500;
   endfunction
   function automatic int exp_ma(input int s);
      return s == 0 ? 155 : s == 1 ? 245 : s == 2 ? 365 : 460;
   endfunction
   task automatic tk(input int k);
      repeat (k) @(posedge mclk);
   endtask
   task automatic chk(input logic [21:0] got, input logic [21:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // bounded wait; running out ends the run
   task automatic wait_on(input logic v, input int lim);
      for (int i = 0; i < lim && rail_b_on !== v; i++) @(posedge mclk);
      chk(rail_b_on, v);
      if (rail_b_on !== v) final_report();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      chk(reg_rdata, e);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst, reg_wr, reg_rd, seq_on_trig, light_sleep_mode, deep_sleep_mode} = 6'h20;
      {upstream_off, current_limit_hit, ref_is_600mv} = 3'h0;
      {reg_addr, reg_wdata, rail_b_voltage_code} = 24'h0;
      failures = 0;
      total_checks = 0;
      void'($urandom(32'h9e07));
      tk(3);
      rst <= 1'b0;
      rd(RRS_ADDR_CTRL, 8'h90);
      rd(RRS_ADDR_DLY, 8'hA2);
      rd(RRS_ADDR_RSVD, 8'h40);
      rd(8'h6A, 8'h00);
      seq_on_trig <= 1'b1;
      tk(4);
      chk(rail_b_on, 1'b0);
      wait_on(1'b1, 20);
      for (n = 0; n < 4; n++) begin
         wr(RRS_ADDR_CTRL, {3'b100, n[1:0], 3'b000});
         tk(3);
         chk(rail_b_limit_ma, 22'(exp_ma(n)));
      end
      repeat (4) begin
         @(posedge mclk);
         rail_b_voltage_code <= 8'($urandom);
         ref_is_600mv <= 1'($urandom);
         tk(3);
         chk(rail_b_target_uv, 22'(exp_uv(rail_b_voltage_code, ref_is_600mv)));
      end
      // light sleep off after a random delay, reset output tied in
      n = 1 + $urandom % 6;
      // off delay runs n full ticks after the 4-cycle pin sync; on code 10 is two ticks
      wr(RRS_ADDR_DLY, {3'b110, n[4:0]});
      wr(RRS_ADDR_CTRL, 8'hD4);
      light_sleep_mode <= 1'b1;
      tk(n * 10 + 5);
      chk(rail_b_on, 1'b1);
      wait_on(1'b0, 16);
      tk(2);
      chk(system_reset_out, 1'b0);
      light_sleep_mode <= 1'b0;
      tk(25);
      chk(rail_b_on, 1'b0);
      wait_on(1'b1, 8);
      tk(3);
      chk(system_reset_out, 1'b1);
      // deep sleep with zero off delay, then deep sleep kept on
      wr(RRS_ADDR_DLY, 8'h80);
      wr(RRS_ADDR_CTRL, 8'hB0);
      deep_sleep_mode <= 1'b1;
      wait_on(1'b0, 10);
      chk(system_reset_out, 1'b1);
      deep_sleep_mode <= 1'b0;
      wait_on(1'b1, 8);
      wr(RRS_ADDR_CTRL, 8'h90);
      deep_sleep_mode <= 1'b1;
      tk(40);
      chk(rail_b_on, 1'b1);
      deep_sleep_mode <= 1'b0;
      // current limit with and without shutdown
      wr(RRS_ADDR_CTRL, 8'h92);
      current_limit_hit <= 1'b1;
      wait_on(1'b0, 10);
      current_limit_hit <= 1'b0;
      tk(29);
      chk(rail_b_on, 1'b0);
      wait_on(1'b1, 40);
      wr(RRS_ADDR_CTRL, 8'h90);
      current_limit_hit <= 1'b1;
      tk(20);
      chk(rail_b_on, 1'b1);
      current_limit_hit <= 1'b0;
      // upstream drop with hold set, then cleared with longest on delay
      upstream_off <= 1'b1;
      tk(20);
      chk(rail_b_on, 1'b1);
      upstream_off <= 1'b0;
      tk(6);
      wr(RRS_ADDR_DLY, 8'h62);
      upstream_off <= 1'b1;
      wait_on(1'b0, 10);
      tk(8);
      upstream_off <= 1'b0;
      tk(46);
      chk(rail_b_on, 1'b0);
      wait_on(1'b1, 16);
      wr(RRS_ADDR_DLY, 8'hA2);
      // disable drops the rail without touching reset output
      wr(RRS_ADDR_CTRL, 8'h10);
      wait_on(1'b0, 5);
      chk(system_reset_out, 1'b1);
      wr(RRS_ADDR_CTRL, 8'h90);
      wait_on(1'b1, 30);
      final_report();
   end
endmodule
